// ==== logic/pixel_map_regs.vh ====
// constants for the flat-panel pixel output mapper
`ifndef PIXEL_MAP_REGS_VH
`define PIXEL_MAP_REGS_VH
`define LANE_W 8
`define BUS_W 24
`define BLUE_LSB 0
`define GREEN_LSB 8
`define RED_LSB 16
`define LSB_KEEP_18 2
`define SKID_DEPTH 2
`define PIX_RESET_VAL 24'h000000
`define CLK_PERIOD_NS 100
`define LINK_PERIOD_NS 800
`endif

// ==== logic/pixel_skid.v ====
// two-entry valid/ready buffer for pixel words
`default_nettype none
module pixel_skid #(
  parameter WIDTH = 52
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wp_reg;
  reg rp_reg;
  reg [1:0] cnt_reg;
  wire push;
  wire pop;
  // honest full/empty from the occupancy count
  assign wr_ready_out = (cnt_reg != 2'h2);
  assign rd_valid_out = (cnt_reg != 2'h0);
  assign rd_data_out = mem_reg[rp_reg];
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_valid_out & rd_ready_in;
  // pointer and count update, frozen while enable is low
  always @(posedge clk_in) begin
    if (rst_in) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (ce_in) begin
      if (push) begin
        mem_reg[wp_reg] <= wr_data_in;
        wp_reg <= ~wp_reg;
      end
      if (pop) rp_reg <= ~rp_reg;
      if (push & ~pop) cnt_reg <= cnt_reg + 2'h1;
      else if (pop & ~push) cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule // pixel_skid
`default_nettype wire

// ==== logic/tft_pixel_output_mapper.v ====
// maps decoded link pixels onto the even/odd flat-panel buses
// Behaviour
// [RQ1] one pixel, 24 bpp: blue 7:0, green 15:8, red 23:16 on even bus
// [RQ2] 18 bpp: six MSB-justified bits per colour, blue 7:2, green 15:10, red 23:18
// [RQ3] two pixels, 24 bpp: first pixel on even bus, second on odd bus
// [RQ4] two pixels, 18 bpp: second pixel's six bits on odd 7:2, 15:10, 23:18
// [RQ5] source should use six of eight bits and hold unused bits low
// [RQ6] pixel data only in active video; syncs conveyed during blanking
// [RQ7] lane zero is blue, lane one green, lane two red
// [RQ8] packing depends only on receiver config, never transmitter input width
// [RQ9] drive pixel clock, vsync, hsync and data enable beside the buses
// [RQ10] static mode inputs select pixels per clock and depth; odd bus low single
`include "pixel_map_regs.vh"
`default_nettype none
module tft_pixel_output_mapper #(
  parameter LANE_W = `LANE_W
) (
  // clock, reset, enable
  input wire CLK_IN,
  input wire RST_IN,
  input wire CE_IN,
  // static configuration pins
  input wire DUAL_PIXEL_IN,
  input wire DEPTH_18_IN,
  // decoded pixel stream from the receiver core
  input wire [LANE_W-1:0] LINK_LANE_ZERO_IN,
  input wire [LANE_W-1:0] LINK_LANE_ONE_IN,
  input wire [LANE_W-1:0] LINK_LANE_TWO_IN,
  input wire PIX_VALID_IN,
  input wire ACTIVE_IN,
  input wire HSYNC_IN,
  input wire VSYNC_IN,
  output reg PIX_READY_OUT,
  // recovered link clock, sampled as a plain level
  input wire LINK_CLK_IN,
  // panel side
  output reg [3*LANE_W-1:0] EVEN_PIXEL_BUS_OUT,
  output reg [3*LANE_W-1:0] ODD_PIXEL_BUS_OUT,
  output reg ACTIVE_VIDEO_QUALIFIER_OUT,
  output reg HSYNC_OUT,
  output reg VSYNC_OUT,
  output reg OUTPUT_PIXEL_CLOCK_OUT,
  input wire PANEL_READY_IN
);
  localparam PIX_W = 3 * LANE_W;
  localparam WORD_W = 2 * PIX_W + 3;
  localparam ST_FIRST = 1'b0;
  localparam ST_SECOND = 1'b1;

  // pack one pixel into bus order, trimming to 6 MSBs in 18 bpp mode
  function [PIX_W-1:0] pack_pixel;
    input [LANE_W-1:0] b;
    input [LANE_W-1:0] g;
    input [LANE_W-1:0] r;
    input d18;
    reg [LANE_W-1:0] mask;
    begin
      mask = d18 ? {{(LANE_W-2){1'b1}}, 2'b00} : {LANE_W{1'b1}}; // [RQ2] [RQ4]
      pack_pixel = {r & mask, g & mask, b & mask}; // [RQ1] [RQ3] [RQ7]
    end
  endfunction

  reg dual_reg;
  reg d18_reg;
  reg lclk_s1_reg;
  reg lclk_s2_reg;
  reg state_reg;
  reg [PIX_W-1:0] first_reg;
  reg [WORD_W-1:0] word_next;
  reg word_valid_next;
  reg take_next;
  wire [PIX_W-1:0] cur_pix;
  wire in_ready;
  wire [WORD_W-1:0] out_word;
  wire out_valid;

  // input pixel packed with the latched configuration only
  assign cur_pix = pack_pixel(LINK_LANE_ZERO_IN, LINK_LANE_ONE_IN,
                              LINK_LANE_TWO_IN, d18_reg); // [RQ8]

  // mode pins latched only while idle, with no pixel offered and no half pair held, so mid-frame toggling cannot tear pixels
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      dual_reg <= 1'b0;
      d18_reg <= 1'b0;
    end else if (CE_IN & (state_reg == ST_FIRST) & ~PIX_VALID_IN) begin
      dual_reg <= DUAL_PIXEL_IN; // [RQ10]
      d18_reg <= DEPTH_18_IN; // [RQ10]
    end
  end

  // two-flop synchroniser for the link clock level
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      lclk_s1_reg <= 1'b0;
      lclk_s2_reg <= 1'b0;
      OUTPUT_PIXEL_CLOCK_OUT <= 1'b0;
    end else if (CE_IN) begin
      lclk_s1_reg <= LINK_CLK_IN;
      lclk_s2_reg <= lclk_s1_reg;
      OUTPUT_PIXEL_CLOCK_OUT <= lclk_s2_reg; // [RQ9]
    end
  end

  // build one bus word: a single pixel, or a pair in dual mode
  always @* begin
    word_next = {WORD_W{1'b0}};
    word_valid_next = 1'b0;
    take_next = 1'b0;
    if (PIX_VALID_IN & in_ready) begin
      if (~ACTIVE_IN) begin
        // blanking: syncs only, buses zero
        word_next = {VSYNC_IN, HSYNC_IN, 1'b0, {PIX_W{1'b0}}, `PIX_RESET_VAL}; // [RQ6]
        word_valid_next = 1'b1;
        take_next = 1'b1;
      end else if (~dual_reg) begin
        word_next = {VSYNC_IN, HSYNC_IN, 1'b1, {PIX_W{1'b0}}, cur_pix}; // [RQ1] [RQ10]
        word_valid_next = 1'b1;
        take_next = 1'b1;
      end else if (state_reg == ST_FIRST) begin
        take_next = 1'b1; // hold first pixel until its partner arrives
      end else begin
        word_next = {VSYNC_IN, HSYNC_IN, 1'b1, cur_pix, first_reg}; // [RQ3] [RQ4]
        word_valid_next = 1'b1;
        take_next = 1'b1;
      end
    end
  end

  // pairing state; a blank word drops a half pair left over at line end
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_FIRST;
      first_reg <= `PIX_RESET_VAL;
    end else if (CE_IN & take_next) begin
      case (state_reg)
        ST_FIRST: begin
          if (dual_reg & ACTIVE_IN) begin
            first_reg <= cur_pix; // [RQ3]
            state_reg <= ST_SECOND;
          end
        end
        ST_SECOND: state_reg <= ST_FIRST;
        default: state_reg <= ST_FIRST;
      endcase
    end
  end

  pixel_skid #(
    .WIDTH(WORD_W)
  ) u_skid (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .wr_data_in(word_next),
    .wr_valid_in(word_valid_next),
    .wr_ready_out(in_ready),
    .rd_data_out(out_word),
    .rd_valid_out(out_valid),
    .rd_ready_in(PANEL_READY_IN)
  );

  // registered panel outputs; hold last value while the panel stalls
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      EVEN_PIXEL_BUS_OUT <= `PIX_RESET_VAL;
      ODD_PIXEL_BUS_OUT <= `PIX_RESET_VAL;
      ACTIVE_VIDEO_QUALIFIER_OUT <= 1'b0;
      HSYNC_OUT <= 1'b0;
      VSYNC_OUT <= 1'b0;
      PIX_READY_OUT <= 1'b0;
    end else if (CE_IN) begin
      PIX_READY_OUT <= in_ready;
      if (out_valid & PANEL_READY_IN) begin
        EVEN_PIXEL_BUS_OUT <= out_word[PIX_W-1:0]; // [RQ1]
        ODD_PIXEL_BUS_OUT <= out_word[2*PIX_W-1:PIX_W]; // [RQ3] [RQ10]
        ACTIVE_VIDEO_QUALIFIER_OUT <= out_word[2*PIX_W]; // [RQ6] [RQ9]
        HSYNC_OUT <= out_word[2*PIX_W+1]; // [RQ9]
        VSYNC_OUT <= out_word[2*PIX_W+2]; // [RQ9]
      end
    end
  end
endmodule // tft_pixel_output_mapper
`default_nettype wire

// ==== tb/mapper_monitor.sv ====
// assertion checker for the pixel output mapper
`default_nettype none
module mapper_monitor #(parameter LANE_W = 8) (
  // clock, modes and source side
  input wire logic CLK_IN, RST_IN, CE_IN, DUAL_PIXEL_IN, DEPTH_18_IN,
  input wire logic [LANE_W-1:0] LINK_LANE_ZERO_IN, LINK_LANE_ONE_IN, LINK_LANE_TWO_IN,
  input wire logic PIX_VALID_IN, ACTIVE_IN, HSYNC_IN, LINK_CLK_IN, PANEL_READY_IN,
  // panel side
  input wire logic [3*LANE_W-1:0] EVEN_PIXEL_BUS_OUT, ODD_PIXEL_BUS_OUT,
  input wire logic ACTIVE_VIDEO_QUALIFIER_OUT, HSYNC_OUT, OUTPUT_PIXEL_CLOCK_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_reg;
  // the clock check waits until the synchroniser has refilled after reset
  always @(posedge CLK_IN) up_reg <= RST_IN ? 2'h0 : up_reg + {1'b0, up_reg != 2'h3};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // an empty pipe, then one beat that the panel takes straight away
  sequence quiet3; (!PIX_VALID_IN && PANEL_READY_IN && CE_IN)[*3]; endsequence
  sequence beat(a); PIX_VALID_IN && ACTIVE_IN == a && !DUAL_PIXEL_IN; endsequence
  a_map_one: assert property (quiet3 ##1 beat(1) ##1 PANEL_READY_IN[*2] |-> ##1
    EVEN_PIXEL_BUS_OUT == ({$past(LINK_LANE_TWO_IN, 3), $past(LINK_LANE_ONE_IN, 3),
    $past(LINK_LANE_ZERO_IN, 3)} & {3{DEPTH_18_IN ? 8'hfc : 8'hff}}))
    else $error("even bus mapping wrong");
  a_sync_blank: assert property (quiet3 ##1 beat(0) ##1 PANEL_READY_IN[*2] |-> ##1
    HSYNC_OUT == $past(HSYNC_IN, 3) && !ACTIVE_VIDEO_QUALIFIER_OUT)
    else $error("blank beat sync wrong");
  a_odd_single: assert property (!DUAL_PIXEL_IN |-> ODD_PIXEL_BUS_OUT == 0)
    else $error("odd bus driven in single mode");
  a_even_low18: assert property (DEPTH_18_IN |-> (EVEN_PIXEL_BUS_OUT & 24'h030303) == 0)
    else $error("even low bits set in 18 bpp");
  a_odd_low18: assert property (DEPTH_18_IN |-> (ODD_PIXEL_BUS_OUT & 24'h030303) == 0)
    else $error("odd low bits set in 18 bpp");
  a_blank_zero: assert property (!ACTIVE_VIDEO_QUALIFIER_OUT |-> EVEN_PIXEL_BUS_OUT == 0)
    else $error("pixel data outside active video");
  a_clk_follow: assert property (up_reg == 2'h3 |-> OUTPUT_PIXEL_CLOCK_OUT == $past(LINK_CLK_IN, 3))
    else $error("pixel clock not link clock delayed");
  a_stall_hold: assert property ($changed(EVEN_PIXEL_BUS_OUT) |-> $past(PANEL_READY_IN))
    else $error("bus changed while panel stalled");
endmodule // mapper_monitor
`default_nettype wire

// ==== tb/panel_model.sv ====
// panel input model: takes every word, or every other one when slow
`default_nettype none
module panel_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic ready_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic toggle_reg = 1'b0;
  // a slow panel stalls every second cycle so held words get exercised
  always @(negedge clk_in) begin
    toggle_reg <= !toggle_reg;
    ready_out <= !slow_in || toggle_reg;
  end
endmodule // panel_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the pixel output mapper
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, dual = 0, d18 = 0, valid = 0, act = 0, hs = 0, vs = 0;
  logic link_clk = 0, slow = 0, rdy, pix_rdy, qual, hs_o, vs_o, pclk;
  logic [7:0] l0 = 0, l1 = 0, l2 = 0;
  logic [23:0] even, odd;
  int n_errors = 0, n_checks = 0;
  initial forever #50 clk = ~clk;
  // link clock free running, phase unrelated to clk
  initial begin #37; forever #400 link_clk = ~link_clk; end
  tft_pixel_output_mapper tft_pixel_output_mapper_i (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .DUAL_PIXEL_IN(dual), .DEPTH_18_IN(d18), .LINK_LANE_ZERO_IN(l0), .LINK_LANE_ONE_IN(l1),
    .LINK_LANE_TWO_IN(l2), .PIX_VALID_IN(valid), .ACTIVE_IN(act), .HSYNC_IN(hs),
    .VSYNC_IN(vs), .PIX_READY_OUT(pix_rdy), .LINK_CLK_IN(link_clk),
    .EVEN_PIXEL_BUS_OUT(even), .ODD_PIXEL_BUS_OUT(odd), .ACTIVE_VIDEO_QUALIFIER_OUT(qual),
    .HSYNC_OUT(hs_o), .VSYNC_OUT(vs_o), .OUTPUT_PIXEL_CLOCK_OUT(pclk), .PANEL_READY_IN(rdy));
  panel_model panel_model_i (.clk_in(clk), .slow_in(slow), .ready_out(rdy));
  task chk(input string what, input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // modes change only under reset, since the mapper latches them when idle
  task do_reset(input logic m_dual, m_d18);
    @(negedge clk) rst = 1; dual = m_dual; d18 = m_d18;
    repeat (2) @(negedge clk);
    rst = 0;
    // idle cycles so the monitor sees an empty pipe before the first beat
    repeat (3) @(negedge clk);
  endtask
  // beat held until ready is seen at a rising edge
  task send(input logic a, input logic [23:0] px);
    @(negedge clk) valid = 1; act = a; {l2, l1, l0} = px; hs = !a; vs = !a;
    do @(posedge clk); while (pix_rdy !== 1'b1);
  endtask
  task settle;
    @(negedge clk) valid = 0;
    repeat (8) @(negedge clk);
  endtask
  task t_single(input logic m18);
    logic [23:0] px;
    px = 24'h3ca5c3 & (m18 ? 24'hfcfcfc : 24'hffffff);
    do_reset(0, m18);
    send(1, px);
    settle();
    chk("even single", even, px);
    chk("odd single", odd, 24'h0);
  endtask
  task t_dual(input logic m18);
    logic [23:0] pa, pb;
    pa = 24'hc35a96 & (m18 ? 24'hfcfcfc : 24'hffffff);
    pb = 24'h69f00f & (m18 ? 24'hfcfcfc : 24'hffffff);
    do_reset(1, m18);
    slow = 1;
    send(1, pa);
    send(1, pb);
    settle();
    slow = 0;
    chk("even dual", even, pa);
    chk("odd dual", odd, pb);
  endtask
  task t_blank;
    do_reset(0, 0);
    send(0, 24'h5a5a5a);
    settle();
    chk("blank bus", even, 24'h0);
    chk("syncs", {21'h0, qual, hs_o, vs_o}, 24'h3);
    chk("ready idle", {23'h0, pix_rdy}, 24'h1);
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 2; i++) begin
      t_single(i[0]);
      t_dual(i[0]);
    end
    t_blank();
    close_out();
  end
  // cut a hang short well past the expected run of under a hundred cycles
  initial begin #200000; n_errors++; close_out(); end
endmodule // tb_top
bind tft_pixel_output_mapper mapper_monitor #(.LANE_W(LANE_W)) mapper_monitor_i (.*);
`default_nettype wire
